// ==== dxc_pkg.sv ====
package dxc_pkg;
    // i/o port addresses (16-bit i/o space)
    localparam logic [15:0] PORT_FUNC      = 16'h0018;
    localparam logic [15:0] PORT_RSVD_A    = 16'h0019;
    localparam logic [15:0] PORT_EXEC      = 16'h001A;
    localparam logic [15:0] PORT_RSVD_B    = 16'h001B;
    // function byte fields
    localparam int          CMD_MSB        = 7;
    localparam int          CMD_LSB        = 4;
    localparam int          CHAN_MSB       = 2;
    localparam int          CHAN_LSB       = 0;
    // command codes
    localparam logic [3:0]  CMD_IOADDR     = 4'h0;
    localparam logic [3:0]  CMD_MADDR_WR   = 4'h2;
    localparam logic [3:0]  CMD_MADDR_RD   = 4'h3;
    localparam logic [3:0]  CMD_COUNT_WR   = 4'h4;
    localparam logic [3:0]  CMD_COUNT_RD   = 4'h5;
    localparam logic [3:0]  CMD_STATUS_RD  = 4'h6;
    localparam logic [3:0]  CMD_MODE       = 4'h7;
    localparam logic [3:0]  CMD_ARB        = 4'h8;
    localparam logic [3:0]  CMD_MASK_SET   = 4'h9;
    localparam logic [3:0]  CMD_MASK_CLR   = 4'hA;
    localparam logic [3:0]  CMD_MCLEAR     = 4'hD;
    // reset values and limits
    localparam logic [7:0]  FUNC_RST       = 8'h00;
    localparam logic [3:0]  ARB_RSVD       = 4'hF;
    localparam logic [3:0]  ARB0_RST       = 4'h0;
    localparam logic [3:0]  ARB4_RST       = 4'h4;
    localparam logic [7:0]  MASK_RST       = 8'hFF;
    localparam logic [1:0]  PTR_RST        = 2'h0;
    localparam logic [2:0]  ARB_CH_LO      = 3'h0;
    localparam logic [2:0]  ARB_CH_HI      = 3'h4;
endpackage

// ==== dxc_ptr.sv ====
`timescale 1ns/1ns
// byte pointer: cleared on function write, steps on each execute access
module dxc_ptr (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rstn,
    // control
    input  wire logic       clr,
    input  wire logic       step,
    // pointer
    output logic [1:0]      ptr
);
    import dxc_pkg::*;

    logic [1:0] next_ptr;

    // clear has priority, a new function byte restarts the sequence
    always_comb begin
        next_ptr = ptr;
        if (clr) begin
            next_ptr = PTR_RST;
        end else if (step) begin
            next_ptr = ptr + 2'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ptr <= PTR_RST;
        end else begin
            ptr <= next_ptr;
        end
    end

    a_ptr_clear: assert property (@(posedge mclk) disable iff (!rstn)
        clr |=> ptr == PTR_RST) else $error("byte pointer not cleared");
    a_ptr_step: assert property (@(posedge mclk) disable iff (!rstn)
        (step && !clr) |=> ptr == $past(ptr) + 2'h1) else $error("byte pointer not stepped");
endmodule // dxc_ptr

// ==== dxc_top.sv ====
`timescale 1ns/1ns
module dxc_top (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    // system i/o cycle, one-cycle strobes
    input  wire logic [15:0] io_addr,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [7:0]  io_wdata,
    output logic [7:0]       io_rdata,
    // channel state toward the transfer engine
    input  wire logic [7:0]  chan_tc,
    input  wire logic [7:0]  chan_req,
    output logic [7:0]       chan_mask,
    output logic [3:0]       arb_level_ch0,
    output logic [3:0]       arb_level_ch4,
    output logic [7:0]       chan_mode [8],
    output logic [23:0]      chan_maddr [8],
    output logic [15:0]      chan_ioaddr [8],
    output logic [15:0]      chan_count [8]
);
    import dxc_pkg::*;

    logic [7:0]  func;
    logic [1:0]  ptr;
    logic [7:0]  status_lo;
    logic [7:0]  status_hi;
    logic [7:0]  next_func;
    logic [7:0]  next_mask;
    logic [3:0]  next_arb0;
    logic [3:0]  next_arb4;
    logic [7:0]  next_mode [8];
    logic [23:0] next_maddr [8];
    logic [15:0] next_ioaddr [8];
    logic [15:0] next_count [8];
    logic [7:0]  next_status_lo;
    logic [7:0]  next_status_hi;
    logic [7:0]  next_rdata;
    logic        func_wr;
    logic        exec;
    logic [3:0]  cmd;
    logic [2:0]  ch;

    // replace byte idx of a register with a new value
    function automatic logic [23:0] put_byte(input logic [23:0] v, input logic [1:0] idx,
                                             input logic [7:0] b);
        logic [23:0] r;
        r = v;
        case (idx)
            2'h0: r[7:0] = b;
            2'h1: r[15:8] = b;
            2'h2: r[23:16] = b;
            default: r = v;
        endcase
        return r;
    endfunction

    // pick byte idx, beyond the register width reads zero
    function automatic logic [7:0] get_byte(input logic [23:0] v, input logic [1:0] idx);
        logic [7:0] r;
        r = 8'h00;
        case (idx)
            2'h0: r = v[7:0];
            2'h1: r = v[15:8];
            2'h2: r = v[23:16];
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    // port decode; 0019 and 001B fall through untouched
    assign func_wr = io_wr && (io_addr == PORT_FUNC);
    assign exec    = (io_wr || io_rd) && (io_addr == PORT_EXEC);
    assign cmd     = func[CMD_MSB:CMD_LSB];
    assign ch      = func[CHAN_MSB:CHAN_LSB];

    dxc_ptr u_ptr (
        .mclk (mclk),
        .rstn (rstn),
        .clr  (func_wr),
        .step (exec),
        .ptr  (ptr)
    );

    // register file next state
    always_comb begin
        next_func      = func;
        next_mask      = chan_mask;
        next_arb0      = arb_level_ch0;
        next_arb4      = arb_level_ch4;
        next_mode      = chan_mode;
        next_maddr     = chan_maddr;
        next_ioaddr    = chan_ioaddr;
        next_count     = chan_count;
        next_rdata     = io_rdata;
        // status bits collect events; read clear loses to a new event
        next_status_lo = status_lo | {chan_req[3:0], chan_tc[3:0]};
        next_status_hi = status_hi | {chan_req[7:4], chan_tc[7:4]};
        if (func_wr) begin
            next_func    = io_wdata;
            next_func[3] = 1'b0;
            // direct commands act on the function byte itself
            case (io_wdata[CMD_MSB:CMD_LSB])
                CMD_MASK_SET: next_mask[io_wdata[CHAN_MSB:CHAN_LSB]] = 1'b1;
                CMD_MASK_CLR: next_mask[io_wdata[CHAN_MSB:CHAN_LSB]] = 1'b0;
                CMD_MCLEAR:   next_mask = MASK_RST;
                default:      next_mask = chan_mask;
            endcase
        end else if (exec) begin
            case (cmd)
                CMD_IOADDR: begin
                    if (io_wr && ptr < 2'h2)
                        next_ioaddr[ch] = 16'(put_byte({8'h00, chan_ioaddr[ch]}, ptr,
                                                       io_wdata)); // drop padding byte
                    next_rdata = get_byte({8'h00, chan_ioaddr[ch]}, ptr);
                end
                CMD_MADDR_WR: begin
                    if (io_wr)
                        next_maddr[ch] = put_byte(chan_maddr[ch], ptr, io_wdata);
                end
                CMD_MADDR_RD: next_rdata = get_byte(chan_maddr[ch], ptr);
                CMD_COUNT_WR: begin
                    if (io_wr && ptr < 2'h2)
                        next_count[ch] = 16'(put_byte({8'h00, chan_count[ch]}, ptr, io_wdata));
                end
                CMD_COUNT_RD: next_rdata = get_byte({8'h00, chan_count[ch]}, ptr);
                CMD_STATUS_RD: begin
                    if (io_rd) begin
                        next_rdata = ch[2] ? status_hi : status_lo;
                        if (ch[2])
                            next_status_hi = {chan_req[7:4], chan_tc[7:4]};
                        else
                            next_status_lo = {chan_req[3:0], chan_tc[3:0]};
                    end
                end
                CMD_MODE: begin
                    if (io_wr)
                        next_mode[ch] = io_wdata;
                    next_rdata = chan_mode[ch];
                end
                CMD_ARB: begin
                    // only bits 3..0 kept; other channels write nothing and read the channel 0 level
                    if (io_wr && ch == ARB_CH_LO)
                        next_arb0 = io_wdata[3:0];
                    if (io_wr && ch == ARB_CH_HI)
                        next_arb4 = io_wdata[3:0];
                    next_rdata = {4'h0, (ch == ARB_CH_HI) ? arb_level_ch4 : arb_level_ch0};
                end
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // registers; system reset masks every channel
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            func          <= FUNC_RST;
            chan_mask     <= MASK_RST;
            arb_level_ch0 <= ARB0_RST;
            arb_level_ch4 <= ARB4_RST;
            status_lo     <= 8'h00;
            status_hi     <= 8'h00;
            io_rdata      <= 8'h00;
            for (int i = 0; i < 8; i++) begin
                chan_mode[i]   <= 8'h00;
                chan_maddr[i]  <= 24'h000000;
                chan_ioaddr[i] <= 16'h0000;
                chan_count[i]  <= 16'h0000;
            end
        end else begin
            func          <= next_func;
            chan_mask     <= next_mask;
            arb_level_ch0 <= next_arb0;
            arb_level_ch4 <= next_arb4;
            status_lo     <= next_status_lo;
            status_hi     <= next_status_hi;
            io_rdata      <= next_rdata;
            chan_mode     <= next_mode;
            chan_maddr    <= next_maddr;
            chan_ioaddr   <= next_ioaddr;
            chan_count    <= next_count;
        end
    end

    a_func_rsvd_zero: assert property (@(posedge mclk) disable iff (!rstn)
        func[3] == 1'b0) else $error("function bit 3 not zero");
    a_mask_set: assert property (@(posedge mclk) disable iff (!rstn)
        (func_wr && io_wdata[7:4] == CMD_MASK_SET) |=> chan_mask[$past(io_wdata[2:0])])
        else $error("mask set missed");
    a_mask_clr: assert property (@(posedge mclk) disable iff (!rstn)
        (func_wr && io_wdata[7:4] == CMD_MASK_CLR) |=> !chan_mask[$past(io_wdata[2:0])])
        else $error("mask clear missed");
    a_master_clear: assert property (@(posedge mclk) disable iff (!rstn)
        (func_wr && io_wdata[7:4] == CMD_MCLEAR) |=> chan_mask == MASK_RST)
        else $error("master clear missed");
    a_arb0_write: assert property (@(posedge mclk) disable iff (!rstn)
        (exec && io_wr && !func_wr && cmd == CMD_ARB && ch == ARB_CH_LO)
        |=> arb_level_ch0 == $past(io_wdata[3:0])) else $error("arb level 0 not loaded");
    a_arb4_write: assert property (@(posedge mclk) disable iff (!rstn)
        (exec && io_wr && cmd == CMD_ARB && ch == ARB_CH_HI)
        |=> arb_level_ch4 == $past(io_wdata[3:0])) else $error("arb level 4 not loaded");
    a_status_clear: assert property (@(posedge mclk) disable iff (!rstn)
        (exec && io_rd && cmd == CMD_STATUS_RD && !ch[2] && $past(chan_tc) == 8'h00
         && chan_tc == 8'h00 && chan_req == 8'h00) |=> status_lo == 8'h00)
        else $error("status not cleared by read");
    a_rsvd_port: assert property (@(posedge mclk) disable iff (!rstn)
        (io_addr == PORT_RSVD_A || io_addr == PORT_RSVD_B) |=> $stable(chan_mask)
        && $stable(arb_level_ch0) && $stable(func)) else $error("reserved port had effect");
    a_rd_status: assert property (@(posedge mclk) disable iff (!rstn)
        (exec && io_rd && cmd == CMD_STATUS_RD && ch[2]) |=> io_rdata == $past(status_hi))
        else $error("status read data wrong");
endmodule // dxc_top

// ==== dxc_cpu.sv ====
`timescale 1ns/1ns
// system processor model: one-cycle byte strobes on the i/o bus
module dxc_cpu (
    // clock
    input  wire logic        mclk,
    // i/o cycle
    output logic [15:0]      io_addr,
    output logic             io_wr,
    output logic             io_rd,
    output logic [7:0]       io_wdata
);
    // idle bus shows inverted last values so stale data never looks valid
    initial begin
        io_addr  = 16'hFFFF;
        io_wr    = 1'b0;
        io_rd    = 1'b0;
        io_wdata = 8'hFF;
    end

    // one byte cycle, strobe stands for exactly one edge
    task automatic cyc(input logic [15:0] a, input logic [7:0] d, input logic w);
        @(posedge mclk);
        io_addr  <= a;
        io_wdata <= d;
        io_wr    <= w;
        io_rd    <= !w;
        @(posedge mclk);
        io_wr    <= 1'b0;
        io_rd    <= 1'b0;
        io_addr  <= ~a;
        io_wdata <= ~d;
    endtask
endmodule // dxc_cpu

// ==== dxc_top_tb.sv ====
`timescale 1ns/1ns
module dxc_top_tb;
    import dxc_pkg::*;
    logic        mclk;
    logic        rstn;
    logic [7:0]  chan_tc;
    logic [7:0]  chan_req;
    logic [15:0] io_addr;
    logic        io_wr;
    logic        io_rd;
    logic [7:0]  io_wdata;
    logic [7:0]  io_rdata;
    logic [7:0]  chan_mask;
    logic [3:0]  arb_level_ch0;
    logic [3:0]  arb_level_ch4;
    logic [7:0]  chan_mode [8];
    logic [23:0] chan_maddr [8];
    logic [15:0] chan_ioaddr [8];
    logic [15:0] chan_count [8];
    int          err_total = 0;
    int          n_compared = 0;
    logic [7:0]  exp_q [$];
    logic        rd_q = 1'b0;
    logic [7:0]  v [3];
    logic [3:0]  lvl;
    logic [7:0]  mc [4] = '{8'hA3, 8'hA6, 8'h93, 8'hD0};
    logic [7:0]  me [4] = '{8'hF7, 8'hB7, 8'hBF, 8'hFF};
    logic [3:0]  rc [5] = '{4'h1, 4'hB, 4'hC, 4'hE, 4'hF};

    dxc_cpu i_cpu (.mclk(mclk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
                   .io_wdata(io_wdata));
    dxc_top i_dut (.mclk(mclk), .rstn(rstn), .io_addr(io_addr), .io_wr(io_wr),
                   .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
                   .chan_tc(chan_tc), .chan_req(chan_req), .chan_mask(chan_mask),
                   .arb_level_ch0(arb_level_ch0), .arb_level_ch4(arb_level_ch4),
                   .chan_mode(chan_mode), .chan_maddr(chan_maddr),
                   .chan_ioaddr(chan_ioaddr), .chan_count(chan_count));

    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        if (err_total == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        i_cpu.cyc(a, d, 1'b1);
    endtask

    // read through the execute port, expected byte noted first
    task automatic rd(input logic [7:0] e);
        exp_q.push_back(e);
        i_cpu.cyc(PORT_EXEC, 8'h00, 1'b0);
    endtask

    // read data is valid the cycle after the strobe
    always @(posedge mclk) begin
        rd_q <= io_rd && (io_addr == PORT_EXEC);
        if (rd_q && exp_q.size() == 0)
            chk({24'h0, io_rdata}, 32'hFFFF_FFFF);
        else if (rd_q)
            chk({24'h0, io_rdata}, {24'h0, exp_q.pop_front()});
    end

    // hang guard
    initial begin
        #200000;
        err_total++;
        end_sim;
    end

    initial begin
        rstn = 1'b0;
        chan_tc = 8'h00;
        chan_req = 8'h00;
        v[0] = 8'($urandom(7));
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        @(negedge mclk);
        chk(chan_mask, MASK_RST);
        chk(arb_level_ch0, ARB0_RST);
        chk(arb_level_ch4, ARB4_RST);
        foreach (v[i]) v[i] = 8'($urandom);
        // count, restarted mid-sequence by a fresh function write
        wr(PORT_FUNC, 8'h42);
        wr(PORT_EXEC, 8'h11);
        wr(PORT_FUNC, 8'h42);
        wr(PORT_EXEC, v[0]);
        wr(PORT_EXEC, v[1]);
        @(negedge mclk);
        chk(chan_count[2], {v[1], v[0]});
        wr(PORT_FUNC, 8'h52);
        rd(v[0]);
        rd(v[1]);
        // memory address, three bytes each way
        wr(PORT_FUNC, 8'h25);
        foreach (v[i]) wr(PORT_EXEC, v[i]);
        @(negedge mclk);
        chk(chan_maddr[5], {v[2], v[1], v[0]});
        wr(PORT_FUNC, 8'h35);
        foreach (v[i]) rd(v[i]);
        wr(PORT_FUNC, 8'h07);
        wr(PORT_EXEC, v[2]);
        wr(PORT_EXEC, v[0]);
        @(negedge mclk);
        chk(chan_ioaddr[7], {v[0], v[2]});
        // read back, third byte of a 16-bit register reads zero
        wr(PORT_FUNC, 8'h07);
        rd(v[2]);
        rd(v[0]);
        rd(8'h00);
        wr(PORT_FUNC, 8'h77);
        wr(PORT_EXEC, v[1]);
        @(negedge mclk);
        chk(chan_mode[7], v[1]);
        wr(PORT_FUNC, 8'h7F);
        rd(v[1]);
        // direct mask commands, no execute access
        for (int i = 0; i < 4; i++) begin
            wr(PORT_FUNC, mc[i]);
            @(negedge mclk);
            chk(chan_mask, me[i]);
        end
        // arbitration levels; reserved level never written
        lvl = 4'($urandom % 15);
        wr(PORT_FUNC, 8'h80);
        wr(PORT_EXEC, {4'h0, lvl});
        wr(PORT_FUNC, 8'h84);
        wr(PORT_EXEC, {4'h0, 4'hE - lvl});
        wr(PORT_FUNC, 8'h82);
        wr(PORT_EXEC, 8'h03);
        @(negedge mclk);
        chk(arb_level_ch0, lvl);
        chk(arb_level_ch4, 4'hE - lvl);
        wr(PORT_FUNC, 8'h84);
        rd({4'h0, 4'hE - lvl});
        // reserved ports and codes leave state alone
        wr(PORT_FUNC, 8'h25);
        wr(PORT_RSVD_A, 8'hA0);
        wr(PORT_RSVD_B, 8'h11);
        foreach (rc[i]) begin
            wr(PORT_FUNC, {rc[i], 4'h5});
            wr(PORT_EXEC, 8'h00);
        end
        @(negedge mclk);
        chk(chan_mask, MASK_RST);
        chk(chan_maddr[5], {v[2], v[1], v[0]});
        wr(PORT_FUNC, 8'h15);
        rd(8'h00);
        // status events, then read-to-clear
        chan_tc <= 8'h02;
        chan_req <= 8'h40;
        @(posedge mclk);
        chan_tc <= 8'h00;
        chan_req <= 8'h00;
        wr(PORT_FUNC, 8'h60);
        rd(8'h02);
        wr(PORT_FUNC, 8'h64);
        rd(8'h40);
        wr(PORT_FUNC, 8'h60);
        rd(8'h00);
        for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge mclk);
        if (exp_q.size() > 0) err_total++;
        end_sim;
    end
endmodule // dxc_top_tb
